// ---- hdl/qtw_pkg.sv ----
// Purpose: shared constants of the quad timer and watchdog unit
// Assumes: one system clock, oscillator pin sampled in that domain
// Notes:   counts are in oscillator rising edges
package qtw_pkg;
	// ==========================================================
	// widths
	localparam int SHORT_W = 12;
	localparam int LONG_W  = 32;
	localparam int WD_W    = 10;
	localparam int DIV_W   = 7;
	// ==========================================================
	// timing counts (low_freq_osc edges per tick)
	localparam int TMR_DIV = 2;
	localparam int WD_DIV  = 128;
	localparam logic [DIV_W-1:0] TMR_DIV_LAST = 7'(TMR_DIV - 1);
	localparam logic [DIV_W-1:0] WD_DIV_LAST  = 7'(WD_DIV - 1);
	// ==========================================================
	// watchdog thresholds and reset values
	localparam logic [WD_W-1:0]  WD_WARN_VAL  = 10'h300;
	localparam logic [WD_W-1:0]  WD_LAST_VAL  = 10'h3ff;
	localparam logic [WD_W-1:0]  WD_RST_VAL   = 10'h000;
	localparam logic [DIV_W-1:0] DIV_RST_VAL  = 7'h00;
	localparam logic [3:0]       STAT_RST_VAL = 4'h0;
endpackage

// ---- hdl/qtw_top.sv ----
// Purpose: four general-purpose timers and a watchdog
// Assumes: control bits come from same-clock software logic
// Notes:   low_freq_osc is sampled as a pin, so it must be < sys_clk/2
//
// Contract
// - two 12-bit timers on system clock, ticked from low_freq_osc
// - two 32-bit timers on system clock
// - software configures all timers and watchdog
// - 12-bit timers tick at low_freq_osc divided two
// - 32-bit timers tick every system clock
// - one match value per timer, no capture
// - second 12-bit timer can chain onto first
// - single-shot or free-running mode per timer
// - per-timer timeout interrupt with own mask
// - all timer events share one output line
// - 10-bit watchdog ticks at low_freq_osc/128
// - watchdog idle until software enables it
// - missed reload while enabled forces system reset
// - watchdog disables itself after its reset
// - watchdog warning value drives non-maskable interrupt
`timescale 1ns/1ps

module qtw_gp_timer #(
	parameter int W = 12
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// control
	input  wire logic         tick_i,
	input  wire logic         enable_i,
	input  wire logic         single_i,
	input  wire logic [W-1:0] match_i,
	// state
	output logic      [W-1:0] count_o,
	output logic              timeout_o,
	output logic              done_o
);
	logic hit;

	assign hit = (count_o == match_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o   <= '0;
			timeout_o <= 1'b0;
			done_o    <= 1'b0;
		end else if (!enable_i) begin
			count_o   <= '0;
			timeout_o <= 1'b0;
			done_o    <= 1'b0;
		end else if (tick_i && !done_o) begin
			timeout_o <= hit;
			count_o   <= hit ? '0 : count_o + 1'b1;
			done_o    <= hit && single_i;
		end else begin
			timeout_o <= 1'b0;
		end
	end
endmodule

module qtw_top
	import qtw_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              arst_n_i,
	// oscillator pin
	input  wire logic              low_freq_osc_i,
	// timer control
	// software set control bits
	input  wire logic [3:0]        tmr_enable_i,
	input  wire logic [3:0]        tmr_single_i,
	input  wire logic              tmr_chain_i,
	input  wire logic [3:0]        tmr_mask_i,
	input  wire logic [3:0]        tmr_clear_i,
	input  wire logic [SHORT_W-1:0] match0_i,
	input  wire logic [SHORT_W-1:0] match1_i,
	input  wire logic [LONG_W-1:0] match2_i,
	input  wire logic [LONG_W-1:0] match3_i,
	// watchdog control
	input  wire logic              wd_enable_i,
	input  wire logic              wd_feed_i,
	// timer state
	output logic [SHORT_W-1:0]     cnt0_o,
	output logic [SHORT_W-1:0]     cnt1_o,
	output logic [LONG_W-1:0]      cnt2_o,
	output logic [LONG_W-1:0]      cnt3_o,
	output logic [3:0]             tmr_status_o,
	output logic                   tmr_irq_o,
	output logic                   timer_line_o,
	// watchdog state
	output logic [WD_W-1:0]        wd_count_o,
	output logic                   wd_active_o,
	output logic                   wd_nmi_o,
	output logic                   sys_rst_req_o
);
	// ==========================================================
	// reset release and oscillator sampling
	logic             rst_s1_q;
	logic             rst_n;
	logic             osc_s1_q;
	logic             osc_s2_q;
	logic             osc_s3_q;
	logic [DIV_W-1:0] div_q;
	logic             lf_tick_q;
	logic             wd_tick_q;
	logic             osc_rise;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// first stage feeds only the second
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end else begin
			osc_s1_q <= low_freq_osc_i;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	assign osc_rise = osc_s2_q && !osc_s3_q;

	// divide by two for short timers
	// divide by 128 for the watchdog
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_q     <= DIV_RST_VAL;
			lf_tick_q <= 1'b0;
			wd_tick_q <= 1'b0;
		end else begin
			div_q     <= osc_rise ? div_q + 1'b1 : div_q;
			lf_tick_q <= osc_rise && ((div_q & TMR_DIV_LAST) == TMR_DIV_LAST);
			wd_tick_q <= osc_rise && (div_q == WD_DIV_LAST);
		end
	end

	// ==========================================================
	// general-purpose timers
	logic [3:0] to;
	logic [3:0] done;
	logic       t1_tick;
	logic       long_tick;

	// chained timer advances on first's timeout
	assign t1_tick   = tmr_chain_i ? to[0] : lf_tick_q;
	assign long_tick = 1'b1;

	qtw_gp_timer #(.W(SHORT_W)) u_t0 (
		.clk_i     (sys_clk_i),
		.rst_n_i   (rst_n),
		.tick_i    (lf_tick_q),
		.enable_i  (tmr_enable_i[0]),
		.single_i  (tmr_single_i[0]),
		.match_i   (match0_i),
		.count_o   (cnt0_o),
		.timeout_o (to[0]),
		.done_o    (done[0])
	);
	// second short timer takes the chain
	qtw_gp_timer #(.W(SHORT_W)) u_t1 (
		.clk_i     (sys_clk_i),
		.rst_n_i   (rst_n),
		.tick_i    (t1_tick),
		.enable_i  (tmr_enable_i[1]),
		.single_i  (tmr_single_i[1]),
		.match_i   (match1_i),
		.count_o   (cnt1_o),
		.timeout_o (to[1]),
		.done_o    (done[1])
	);
	qtw_gp_timer #(.W(LONG_W)) u_t2 (
		.clk_i     (sys_clk_i),
		.rst_n_i   (rst_n),
		.tick_i    (long_tick),
		.enable_i  (tmr_enable_i[2]),
		.single_i  (tmr_single_i[2]),
		.match_i   (match2_i),
		.count_o   (cnt2_o),
		.timeout_o (to[2]),
		.done_o    (done[2])
	);
	qtw_gp_timer #(.W(LONG_W)) u_t3 (
		.clk_i     (sys_clk_i),
		.rst_n_i   (rst_n),
		.tick_i    (long_tick),
		.enable_i  (tmr_enable_i[3]),
		.single_i  (tmr_single_i[3]),
		.match_i   (match3_i),
		.count_o   (cnt3_o),
		.timeout_o (to[3]),
		.done_o    (done[3])
	);

	// ==========================================================
	// status, interrupt and shared line
	logic [3:0] stat_d;

	// set beats clear so no timeout is lost
	assign stat_d = (tmr_status_o & ~tmr_clear_i) | to;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tmr_status_o <= STAT_RST_VAL;
			tmr_irq_o    <= 1'b0;
			timer_line_o <= 1'b0;
		end else begin
			tmr_status_o <= stat_d;
			tmr_irq_o    <= |(stat_d & tmr_mask_i);
			timer_line_o <= |to;
		end
	end

	// ==========================================================
	// watchdog
	logic wd_expire;
	logic wd_warn;

	assign wd_expire = wd_active_o && wd_tick_q && (wd_count_o == WD_LAST_VAL);
	assign wd_warn   = wd_active_o && wd_tick_q && (wd_count_o == WD_WARN_VAL);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_active_o   <= 1'b0;
			wd_count_o    <= WD_RST_VAL;
			wd_nmi_o      <= 1'b0;
			sys_rst_req_o <= 1'b0;
		end else begin
			// expiry clears enable, wins over enable
			wd_active_o   <= !wd_expire && (wd_active_o || wd_enable_i);
			sys_rst_req_o <= wd_expire;
			wd_nmi_o      <= wd_warn;
			if (!wd_active_o || wd_feed_i || wd_expire) begin
				wd_count_o <= WD_RST_VAL;
			end else if (wd_tick_q) begin
				wd_count_o <= wd_count_o + 1'b1;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	property p_short_rate;
		tmr_enable_i[0] && $past(tmr_enable_i[0]) && $changed(cnt0_o) |-> $past(lf_tick_q);
	endproperty
	a_short_rate: assert property (p_short_rate) else $error("short timer moved off tick");

	property p_long_rate;
		tmr_enable_i[2] && !done[2] && cnt2_o != match2_i ##1 tmr_enable_i[2]
			|-> cnt2_o == $past(cnt2_o) + 32'h1;
	endproperty
	a_long_rate: assert property (p_long_rate) else $error("long timer missed a cycle");

	property p_match_wrap;
		tmr_enable_i[2] && !done[2] && cnt2_o == match2_i ##1 tmr_enable_i[2]
			|-> to[2] && cnt2_o == 32'h0 && done[2] == $past(tmr_single_i[2]);
	endproperty
	a_match_wrap: assert property (p_match_wrap) else $error("match handling wrong");

	property p_single_hold;
		done[3] && tmr_enable_i[3] |=> $stable(cnt3_o) && !to[3];
	endproperty
	a_single_hold: assert property (p_single_hold) else $error("single-shot kept counting");

	property p_chain;
		$past(tmr_chain_i) && $past(tmr_enable_i[1]) && $changed(cnt1_o)
			|-> $past(to[0]);
	endproperty
	a_chain: assert property (p_chain) else $error("chained timer moved alone");

	property p_irq;
		##1 tmr_irq_o == |(tmr_status_o & $past(tmr_mask_i));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not masked status");

	property p_line;
		|to |=> timer_line_o;
	endproperty
	a_line: assert property (p_line) else $error("shared line missed event");

	property p_wd_idle;
		!wd_active_o && !wd_enable_i |=> !wd_active_o && wd_count_o == WD_RST_VAL;
	endproperty
	a_wd_idle: assert property (p_wd_idle) else $error("watchdog ran unenabled");

	property p_wd_rate;
		$changed(wd_count_o) && wd_count_o != WD_RST_VAL |-> $past(wd_tick_q);
	endproperty
	a_wd_rate: assert property (p_wd_rate) else $error("watchdog moved off tick");

	property p_wd_expire;
		wd_active_o && wd_tick_q && !wd_feed_i && wd_count_o == WD_LAST_VAL
			|=> sys_rst_req_o && !wd_active_o ##1 !sys_rst_req_o;
	endproperty
	a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry wrong");

	property p_wd_off;
		sys_rst_req_o |-> !wd_active_o && wd_count_o == WD_RST_VAL;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("watchdog stayed on");

	property p_nmi;
		wd_active_o && wd_tick_q && wd_count_o == WD_WARN_VAL |=> wd_nmi_o;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi missing at warning");

	c_wrap:   cover property (to[2] && !tmr_single_i[2] ##1 cnt2_o == 32'h1);
	c_chain:  cover property (tmr_chain_i && to[1]);
	c_nmi:    cover property (wd_nmi_o);
	c_expire: cover property (sys_rst_req_o);
endmodule

// ---- tb/qtw_osc_model.sv ----
// Purpose: oscillator source feeding the timer unit
// Assumes: stepped on bench clock edges
// Notes:   far faster than the real part so runs stay short
`timescale 1ns/1ps

module qtw_osc_model #(
	parameter int HALF = 2
) (
	// clock
	input  wire logic sys_clk_i,
	// oscillator pin
	output logic      low_freq_osc_o
);
	// ==========================================================
	// free-running square wave
	int cnt_q = 0;
	initial low_freq_osc_o = 1'b0;
	always @(posedge sys_clk_i) begin
		if (cnt_q == HALF - 1) begin
			cnt_q <= 0;
			low_freq_osc_o <= ~low_freq_osc_o;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule

// ---- tb/tb_quad_timer_watchdog_unit.sv ----
// Purpose: self-checking bench of the timer and watchdog unit
// Assumes: oscillator sped up to keep run times short
// Notes:   watchdog expiry takes too long to reach here
`timescale 1ns/1ps

module tb_quad_timer_watchdog_unit
	import qtw_pkg::*;
;
	// ==========================================================
	// signals
	localparam int HALF = 2;
	localparam int TPER = 4 * HALF;
	localparam int WPER = 256 * HALF;
	logic sys_clk_i = 1'b0;
	logic arst_n_i  = 1'b0;
	logic osc;
	logic [3:0] en = 4'h0, sg = 4'h0, mk = 4'h0, clr = 4'h0;
	logic chain = 1'b0, wen = 1'b0, wfeed = 1'b0, mon_on = 1'b1;
	logic [SHORT_W-1:0] m0 = 12'h0, m1 = 12'h0, c0, c1;
	logic [LONG_W-1:0]  m2 = 32'h0, m3 = 32'h0, c2, c3;
	logic [3:0] st;
	logic irq, line, wact, nmi, rreq;
	logic [WD_W-1:0] wcnt;
	logic [31:0] seed = 32'h00018278;
	int failures = 0, check_count = 0, cyc = 0, last_t = -1;
	int exp_q[$];
	always #50 sys_clk_i = ~sys_clk_i;

	qtw_osc_model #(.HALF(HALF)) i_osc (.sys_clk_i(sys_clk_i), .low_freq_osc_o(osc));
	qtw_top i_dut (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .low_freq_osc_i(osc),
		.tmr_enable_i(en), .tmr_single_i(sg), .tmr_chain_i(chain),
		.tmr_mask_i(mk), .tmr_clear_i(clr), .match0_i(m0), .match1_i(m1),
		.match2_i(m2), .match3_i(m3), .wd_enable_i(wen), .wd_feed_i(wfeed),
		.cnt0_o(c0), .cnt1_o(c1), .cnt2_o(c2), .cnt3_o(c3),
		.tmr_status_o(st), .tmr_irq_o(irq), .timer_line_o(line),
		.wd_count_o(wcnt), .wd_active_o(wact), .wd_nmi_o(nmi),
		.sys_rst_req_o(rreq)
	);

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task cmp_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==========================================================
	// monitor: spacing of shared-line pulses against the queue
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc > 10000) begin
			failures++;
			results();
		end
		if (line === 1'b1 && mon_on) begin
			if (last_t >= 0 && exp_q.size() > 0) cmp_val(cyc - last_t, exp_q.pop_front());
			else if (last_t >= 0) cmp_val(32'h1, 32'h0);
			last_t <= cyc;
		end
	end

	// ==========================================================
	// one timer run; margin stays below one timeout period
	task run_tmr(input int i, input logic [31:0] m, input logic s, input logic k,
			input int per, input int n);
		int mg;
		mg = (per == 1) ? 2 : per + 6;
		@(posedge sys_clk_i);
		case (i)
			0: m0 <= m[11:0];
			1: m1 <= m[11:0];
			2: m2 <= m;
			default: m3 <= m;
		endcase
		sg[i] <= s;
		mk[i] <= k;
		last_t <= -1;
		if (!s) repeat (n - 1) exp_q.push_back((m + 1) * per);
		@(posedge sys_clk_i) en[i] <= 1'b1;
		repeat (n * (m + 1) * per + mg) @(posedge sys_clk_i);
		en[i] <= 1'b0;
		@(negedge sys_clk_i);
		cmp_val(exp_q.size(), 0);
		cmp_val(st[i], 1'b1);
		cmp_val(irq, k);
		@(posedge sys_clk_i) clr[i] <= 1'b1;
		@(posedge sys_clk_i) clr[i] <= 1'b0;
		@(negedge sys_clk_i);
		cmp_val({st, irq}, 5'h0);
		cmp_val((i == 0) ? c0 : (i == 1) ? c1 : (i == 2) ? c2 : c3, 32'h0);
	endtask

	task wait_wd(output int t);
		int k;
		logic [WD_W-1:0] v;
		k = 0;
		v = wcnt;
		while (wcnt === v && k < WPER + 50) begin
			@(negedge sys_clk_i);
			k++;
		end
		t = cyc;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		int t0, t1;
		logic [WD_W-1:0] v;
		repeat (4) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		// every timer, both modes, both masks
		for (int i = 0; i < 4; i++) begin
			for (int s = 0; s < 2; s++) begin
				run_tmr(i, (i < 2) ? (rnd() % 6) + 2 : (rnd() % 16) + 2, s[0], s[0] ^ i[0],
					(i < 2) ? TPER : 1, 3);
			end
		end
		// chained pair, timer0 times out every 32 cycles
		mon_on <= 1'b0;
		@(posedge sys_clk_i);
		m0 <= 12'h003;
		m1 <= 12'h002;
		sg <= 4'h0;
		chain <= 1'b1;
		@(posedge sys_clk_i) en <= 4'h3;
		repeat (80) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		cmp_val({c1, st[1]}, {12'h002, 1'b0});
		repeat (40) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		cmp_val(st[1], 1'b1);
		@(posedge sys_clk_i) en <= 4'h0;
		wfeed <= 1'b1;
		@(posedge sys_clk_i) wfeed <= 1'b0;
		repeat (2 * WPER) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		cmp_val({wact, wcnt}, 11'h0);
		@(posedge sys_clk_i) wen <= 1'b1;
		@(posedge sys_clk_i) wen <= 1'b0;
		@(negedge sys_clk_i);
		cmp_val(wact, 1'b1);
		wait_wd(t0);
		v = wcnt;
		wait_wd(t1);
		cmp_val(t1 - t0, WPER);
		cmp_val(wcnt, v + 10'h001);
		@(posedge sys_clk_i) wfeed <= 1'b1;
		@(posedge sys_clk_i) wfeed <= 1'b0;
		@(negedge sys_clk_i);
		cmp_val({wact, wcnt, nmi, rreq}, {1'b1, 12'h0});
		// second reset in mid-run leaves the watchdog off
		@(posedge sys_clk_i) arst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		cmp_val({wact, wcnt, rreq}, 12'h0);
		@(posedge sys_clk_i) arst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		cmp_val({wact, wcnt, rreq}, 12'h0);
		results();
	end
endmodule
